// ---- logic/acl_pkg.sv ----
package acl_pkg;

   // clock rates
   localparam int unsigned REF_CLK_HZ      = 125000000;
   localparam int unsigned BIT_CLK_HZ      = 12288000;
   localparam int unsigned SAMPLE_HZ       = 48000;
   localparam int unsigned BCLK_PER_SAMPLE = BIT_CLK_HZ / SAMPLE_HZ;

   // bit clock phase accumulator, one carry per half period
   localparam int                ACC_W     = 24;
   localparam longint            ACC_INC_L = (longint'(2 * BIT_CLK_HZ) << ACC_W)
                                             / longint'(REF_CLK_HZ);
   localparam logic [ACC_W-1:0]  ACC_INC   = ACC_INC_L[ACC_W-1:0];

   // frame layout
   localparam int TAG_W      = 16;
   localparam int SLOT_W     = 20;
   localparam int NUM_SLOTS  = 12;
   localparam int FRAME_BITS = TAG_W + NUM_SLOTS * SLOT_W;
   localparam int FCNT_W     = 9;
   localparam logic [FCNT_W-1:0] FRAME_LAST = FCNT_W'(FRAME_BITS);

   localparam int TAG_READY_BIT = 15;
   localparam int TAG_SLOT1_BIT = 14;
   localparam int IDX_LSB       = 12;
   localparam int DATA_LSB      = 4;
   localparam int PCM_W         = 18;
   localparam int PCM_SENT_W    = 16;

   // power-down register and its halt bit
   localparam logic [6:0] PD_REG_INDEX = 7'h26;
   localparam int         HALT_BIT     = 12;

   // apb map
   localparam int          ADDR_W     = 12;
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_FRAMES = 12'h008;
   localparam logic [11:0] REG_WAKES  = 12'h00C;
   localparam int          CTRL_READY_EN_BIT = 0;
   localparam logic        CTRL_READY_EN_RST = 1'b1;
   localparam int          ST_READY_BIT  = 0;
   localparam int          ST_HALTED_BIT = 1;
   localparam int          ST_STATP_BIT  = 2;
   localparam int          ST_PCMP_BIT   = 3;
   localparam int          ST_SHIFT_BIT  = 4;

   typedef struct packed {
      logic [6:0]  index;
      logic [15:0] data;
   } acl_regwr_t;

   typedef struct packed {
      logic [6:0]  index;
      logic [15:0] data;
   } acl_stat_t;

   typedef struct packed {
      logic [PCM_W-1:0] left;
      logic [PCM_W-1:0] right;
   } acl_pcm_t;

   typedef enum logic [1:0] {
      ST_WAIT,
      ST_SHIFT,
      ST_HALT
   } acl_state_t;

endpackage

// ---- logic/acl_bclk_gen.sv ----
`timescale 1ns/1ps
module acl_bclk_gen
   import acl_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // control
   input  wire logic run,
   // bit clock
   output logic      bclk_q,
   output logic      rise
);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W:0]   sum;

   assign sum  = {1'b0, acc_q} + {1'b0, ACC_INC};
   assign rise = ce && run && sum[ACC_W] && !bclk_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q  <= '0;
         bclk_q <= 1'b0;
      end
      else if (ce)
      begin
         if (!run)
         begin
            acc_q  <= '0;
            bclk_q <= 1'b0;
         end
         else
         begin
            acc_q <= sum[ACC_W-1:0];
            if (sum[ACC_W])
               bclk_q <= ~bclk_q;
         end
      end
   end

endmodule

// ---- logic/acl_frame_out.sv ----
// What this block does
// - tag bit 15 shows codec ready once registers and link work; here it copies the CTRL ready enable bit
// - tag bit 14 flags slot one valid, only when ready; else zeros
// - tag bits 13..3 flag other slots; invalid slots sent as zeros
// - tag bits 2..0, slot one bits 19 and 11..0, slot two 3..0 zero
// - slot one bits 18..12 echo the reported register index
// - slot two bits 19..4 carry that register's contents
// - invalid status slots send zero index and data
// - slots three and four carry left and right record samples
// - slots five to twelve are sent as all zeros
// - write of 26h with halt bit drives bit clock and data low
// - low right after decoding that write, no further frames
// - halted link resumes only by warm or cold reset
// - sync raised while bit clock stopped wakes the link
// - warm reset keeps all programmed register contents
// - cold reset pin restarts link and defaults every register
// - reset pin and sync are synchronised internally
// - bit clock runs at 12.288 MHz, 256 times 48 kHz
// - data changes on rising bit clock edges
`timescale 1ns/1ps
module acl_frame_out
   import acl_pkg::*;
(
   // clock, reset, enable
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              ce,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // link pins
   input  wire logic              sync,
   output logic                   link_bit_clock,
   output logic                   codec_to_ctrl_data,
   // register writes decoded from the output frame
   input  wire logic              reg_wr_valid,
   input  wire acl_regwr_t        reg_wr,
   // register status report
   input  wire logic              stat_valid,
   input  wire acl_stat_t         stat,
   output logic                   stat_ready,
   // record samples
   input  wire logic              pcm_valid,
   input  wire acl_pcm_t          pcm,
   // state
   output logic                   codec_ready,
   output logic                   link_halted
);

   logic                  rst_meta_q;
   logic                  rst_n;
   logic                  sync_meta_q;
   logic                  sync_s_q;
   logic                  sync_d_q;
   logic                  sync_rise;
   logic                  bclk_rise;
   logic                  halt_req;
   logic                  run;
   acl_state_t            state_q;
   logic                  start_pend_q;
   logic [FCNT_W-1:0]     cnt_q;
   logic [FRAME_BITS-1:0] shreg_q;
   logic                  sdo_q;
   logic                  ready_q;
   logic                  ready_en_q;
   logic                  stat_pend_q;
   acl_stat_t             stat_q;
   logic                  pcm_pend_q;
   acl_pcm_t              pcm_q;
   logic                  load;
   logic [FRAME_BITS-1:0] next_frame;
   logic [31:0]           frames_q;
   logic [31:0]           wakes_q;
   logic [31:0]           prdata_q;
   logic                  rd_vld_q;
   logic                  wake;

   // slot n's most significant bit within the frame vector
   function automatic int slot_msb(input int n);
      return FRAME_BITS - 1 - TAG_W - (n - 1) * SLOT_W;
   endfunction

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
      return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_FRAMES) ||
             (a == REG_WAKES);
   endfunction

   function automatic logic [FRAME_BITS-1:0] build_frame(
      input logic      rdy,
      input logic      sv,
      input acl_stat_t s,
      input logic      pv,
      input acl_pcm_t  p
   );
      logic [FRAME_BITS-1:0] f;
      logic                  s_ok;
      logic                  p_ok;
      f    = '0;
      s_ok = rdy && sv;
      p_ok = rdy && pv;
      f[FRAME_BITS-TAG_W+TAG_READY_BIT] = rdy;
      f[FRAME_BITS-TAG_W+TAG_SLOT1_BIT] = s_ok;
      f[FRAME_BITS-TAG_W+TAG_SLOT1_BIT-1] = s_ok;
      f[FRAME_BITS-TAG_W+TAG_SLOT1_BIT-2] = p_ok;
      f[FRAME_BITS-TAG_W+TAG_SLOT1_BIT-3] = p_ok;
      if (s_ok)
      begin
         f[slot_msb(1) -: SLOT_W] = {1'b0, s.index, {IDX_LSB{1'b0}}};
         f[slot_msb(2) -: SLOT_W] = {s.data, {DATA_LSB{1'b0}}};
      end
      if (p_ok)
      begin
         f[slot_msb(3) -: SLOT_W] = {p.left[PCM_W-1 -: PCM_SENT_W],
                                     {DATA_LSB{1'b0}}};
         f[slot_msb(4) -: SLOT_W] = {p.right[PCM_W-1 -: PCM_SENT_W],
                                     {DATA_LSB{1'b0}}};
      end
      // slots five to twelve and pads remain zero
      return f;
   endfunction

   // cold reset released through two flops
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_meta_q <= 1'b0;
         sync_s_q    <= 1'b0;
         sync_d_q    <= 1'b0;
      end
      else if (ce)
      begin
         sync_meta_q <= sync;
         sync_s_q    <= sync_meta_q;
         sync_d_q    <= sync_s_q;
      end
   end

   assign sync_rise = ce && sync_s_q && !sync_d_q;

   assign halt_req = ce && reg_wr_valid && (reg_wr.index == PD_REG_INDEX) &&
                     reg_wr.data[HALT_BIT] && (state_q != ST_HALT);
   assign wake     = sync_rise && (state_q == ST_HALT);
   // clock stops at the decoding edge
   assign run      = (state_q != ST_HALT) && !halt_req;

   acl_bclk_gen u_bclk (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .run     (run),
      .bclk_q  (link_bit_clock),
      .rise    (bclk_rise)
   );

   assign load = bclk_rise && start_pend_q;
   assign next_frame = build_frame(ready_en_q, stat_pend_q, stat_q, pcm_pend_q, pcm_q);

   // link state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_WAIT;
      else if (ce)
      begin
         unique case (state_q)
            ST_WAIT:
            begin
               if (halt_req)
                  state_q <= ST_HALT;
               else if (load)
                  state_q <= ST_SHIFT;
            end
            ST_SHIFT:
            begin
               if (halt_req)
                  state_q <= ST_HALT;
               else if (bclk_rise && !start_pend_q && cnt_q == FRAME_LAST)
                  state_q <= ST_WAIT;
            end
            ST_HALT:
            begin
               // only a wake or cold reset leaves
               if (wake)
                  state_q <= ST_WAIT;
            end
            default:
               state_q <= ST_WAIT;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         start_pend_q <= 1'b0;
      else if (ce)
      begin
         if (halt_req || state_q == ST_HALT)
            start_pend_q <= 1'b0;
         else if (sync_rise)
            start_pend_q <= 1'b1;
         else if (load)
            start_pend_q <= 1'b0;
      end
   end

   // shift out on rising bit clock edges, msb first
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shreg_q <= '0;
         cnt_q   <= '0;
         sdo_q   <= 1'b0;
      end
      else if (ce)
      begin
         if (halt_req || state_q == ST_HALT)
         begin
            shreg_q <= '0;
            cnt_q   <= '0;
            sdo_q   <= 1'b0;
         end
         else if (load)
         begin
            shreg_q <= {next_frame[FRAME_BITS-2:0], 1'b0};
            sdo_q   <= next_frame[FRAME_BITS-1];
            cnt_q   <= FCNT_W'(1);
         end
         else if (bclk_rise && state_q == ST_SHIFT)
         begin
            if (cnt_q == FRAME_LAST)
               sdo_q <= 1'b0;
            else
            begin
               sdo_q   <= shreg_q[FRAME_BITS-1];
               shreg_q <= shreg_q << 1;
               cnt_q   <= cnt_q + FCNT_W'(1);
            end
         end
      end
   end

   assign codec_to_ctrl_data = sdo_q;

   // ready latched per frame, cold reset clears
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ready_q <= 1'b0;
      else if (ce && load)
         ready_q <= ready_en_q;
   end

   // pending status report, a new one wins over the frame that consumes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stat_pend_q <= 1'b0;
         stat_q      <= '0;
      end
      else if (ce)
      begin
         if (stat_valid && stat_ready)
         begin
            stat_pend_q <= 1'b1;
            stat_q      <= stat;
         end
         else if (load && ready_en_q)
            stat_pend_q <= 1'b0;
      end
   end

   assign stat_ready = !stat_pend_q;

   // latest record sample pair
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pcm_pend_q <= 1'b0;
         pcm_q      <= '0;
      end
      else if (ce)
      begin
         if (pcm_valid)
         begin
            pcm_pend_q <= 1'b1;
            pcm_q      <= pcm;
         end
         else if (load && ready_en_q)
            pcm_pend_q <= 1'b0;
      end
   end

   // counters and control survive a warm wake
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frames_q <= '0;
         wakes_q  <= '0;
      end
      else if (ce)
      begin
         if (load)
            frames_q <= frames_q + 32'h0000_0001;
         if (wake)
            wakes_q <= wakes_q + 32'h0000_0001;
      end
   end

   // apb control register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ready_en_q <= CTRL_READY_EN_RST;
      else if (ce && psel && penable && pwrite && rd_vld_q &&
               paddr == REG_CTRL)
         ready_en_q <= pwdata[CTRL_READY_EN_BIT];
   end

   // apb read data captured in setup, answered in access
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_q <= '0;
         rd_vld_q <= 1'b0;
      end
      else if (ce)
      begin
         if (psel && !penable)
         begin
            rd_vld_q <= 1'b1;
            prdata_q <= '0;
            unique case (paddr)
               REG_CTRL:   prdata_q[CTRL_READY_EN_BIT] <= ready_en_q;
               REG_STATUS:
               begin
                  prdata_q[ST_READY_BIT]  <= ready_q;
                  prdata_q[ST_HALTED_BIT] <= state_q == ST_HALT;
                  prdata_q[ST_STATP_BIT]  <= stat_pend_q;
                  prdata_q[ST_PCMP_BIT]   <= pcm_pend_q;
                  prdata_q[ST_SHIFT_BIT]  <= state_q == ST_SHIFT;
               end
               REG_FRAMES: prdata_q <= frames_q;
               REG_WAKES:  prdata_q <= wakes_q;
               default:    prdata_q <= '0;
            endcase
         end
         else if (psel && penable)
            rd_vld_q <= 1'b0;
      end
   end

   assign prdata      = prdata_q;
   assign pready      = ce && rd_vld_q;
   assign pslverr     = ce && rd_vld_q && psel && penable && !reg_mapped(paddr);
   assign codec_ready = ready_q;
   assign link_halted = state_q == ST_HALT;

endmodule

// ---- bench/acl_frame_out_sva.sv ----
`timescale 1ns/1ps
module acl_frame_out_sva
   import acl_pkg::*;
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rstn,
   // link and state
   input wire logic       sync,
   input wire logic       link_bit_clock,
   input wire logic       codec_to_ctrl_data,
   input wire logic       link_halted,
   input wire logic       codec_ready,
   // register and status side
   input wire logic       reg_wr_valid,
   input wire acl_regwr_t reg_wr,
   input wire logic       stat_valid,
   input wire logic       stat_ready
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   logic [3:0] hp_q;
   logic       seen_q;
   logic       halt_cmd;

   assign halt_cmd = reg_wr_valid && reg_wr.index == PD_REG_INDEX && reg_wr.data[HALT_BIT];

   // ref clocks since the last bit clock edge
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         hp_q <= 4'h0;
      else if ($changed(link_bit_clock))
         hp_q <= 4'h0;
      else if (hp_q != 4'hF)
         hp_q <= hp_q + 4'h1;
   end

   // a full half period has been seen since the clock last started
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         seen_q <= 1'h0;
      else
         seen_q <= !link_halted && (seen_q || $changed(link_bit_clock));
   end

   a_bclk_rate: assert property (
      $changed(link_bit_clock) && seen_q && !link_halted |-> hp_q inside {4'h4, 4'h5})
      else $error("bit clock half period wrong");
   a_data_on_rise: assert property (
      $changed(codec_to_ctrl_data) && !link_halted |-> $rose(link_bit_clock))
      else $error("serial data changed off a rising bit clock");
   a_halt_on_write: assert property (
      halt_cmd |=> link_halted)
      else $error("halting write did not halt the link");
   a_halt_only_cmd: assert property (
      !link_halted && !halt_cmd |=> !link_halted)
      else $error("link halted without a halting write");
   a_halt_lines_low: assert property (
      link_halted && $past(link_halted) |-> !link_bit_clock && !codec_to_ctrl_data)
      else $error("bit clock or data not low while halted");
   a_stay_halted: assert property (
      link_halted && !sync && !$past(sync) && !$past(sync, 2) && !$past(sync, 3)
      |=> link_halted)
      else $error("halt left without a wake request");
   a_warm_wake: assert property (
      link_halted && $rose(sync) |-> ##[1:8] !link_halted)
      else $error("sync while halted did not wake the link");
   a_stat_take: assert property (
      stat_valid && stat_ready |=> !stat_ready)
      else $error("status report not held pending");
   a_cold_default: assert property (
      $rose(rstn) |-> !link_halted && !codec_ready && !link_bit_clock && stat_ready)
      else $error("state not at default after cold reset");
endmodule

bind acl_frame_out acl_frame_out_sva chk_u (
   .ref_clk            (ref_clk),
   .rstn               (rstn),
   .sync               (sync),
   .link_bit_clock     (link_bit_clock),
   .codec_to_ctrl_data (codec_to_ctrl_data),
   .link_halted        (link_halted),
   .codec_ready        (codec_ready),
   .reg_wr_valid       (reg_wr_valid),
   .reg_wr             (reg_wr),
   .stat_valid         (stat_valid),
   .stat_ready         (stat_ready)
);

// ---- bench/acl_ctrl_model.sv ----
`timescale 1ns/1ps
module acl_ctrl_model
(
   // clock
   input  wire logic ref_clk,
   // link
   input  wire logic link_bit_clock,
   input  wire logic codec_to_ctrl_data,
   output logic      sync
);
   initial sync = 1'h0;

   // frame opens on sync rise, 256 bits msb first
   task automatic get_frame(output logic [255:0] f);
      f = '0;
      @(posedge link_bit_clock);
      sync <= 1'h1;
      @(posedge link_bit_clock);
      for (int i = 0; i < 256; i++)
      begin
         @(negedge link_bit_clock);
         f = {f[254:0], codec_to_ctrl_data};
         if (i == 15)
            sync <= 1'h0;
      end
   endtask

   // warm wake, sync raised with bit clock stopped
   task automatic wake();
      @(posedge ref_clk);
      sync <= 1'h1;
      repeat (40) @(posedge ref_clk);
      sync <= 1'h0;
      @(posedge ref_clk);
   endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import acl_pkg::*;
();
   logic              ref_clk, rstn, ce, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic              sync, link_bit_clock, codec_to_ctrl_data;
   logic              reg_wr_valid, stat_valid, stat_ready, pcm_valid;
   logic              codec_ready, link_halted;
   acl_regwr_t        reg_wr;
   acl_stat_t         stat;
   acl_pcm_t          pcm;
   int                n_errors, tests_run;
   // bench copy of what the device holds pending for the next frame
   logic              st_pend, pc_pend;
   acl_stat_t         st_exp;
   acl_pcm_t          pc_exp;

   acl_frame_out dut_u (.*);
   acl_ctrl_model ctl_u (.*);

   always #4 ref_clk = ~ref_clk;

   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
         @(posedge ref_clk);
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask

   task automatic wr_reg(input acl_regwr_t w);
      reg_wr       <= w;
      reg_wr_valid <= 1'h1;
      @(posedge ref_clk);
      reg_wr_valid <= 1'h0;
      repeat (2) @(posedge ref_clk);
   endtask

   function automatic logic [255:0] exp_frame(input logic r, input logic sv, input acl_stat_t s,
                                              input logic pv, input acl_pcm_t p);
      logic a;
      logic b;
      a = r & sv;
      b = r & pv;
      return {r, a, a, b, b, 11'h000,
              a ? {1'h0, s.index, 12'h000, s.data, 4'h0} : 40'h0,
              b ? {p.left[17:2], 4'h0, p.right[17:2], 4'h0} : 40'h0, 160'h0};
   endfunction

   task automatic frame(input logic r, input logic sv, input acl_stat_t s,
                        input logic pv, input acl_pcm_t p);
      logic [31:0]  rd;
      logic         er;
      logic [255:0] f;
      apb(1'h1, REG_CTRL, {31'h0, r}, rd, er);
      chk(stat_ready, !st_pend);
      if (sv && !st_pend)
         st_exp = s;
      st_pend = st_pend || sv;
      if (pv)
         pc_exp = p;
      pc_pend = pc_pend || pv;
      stat       <= s;
      pcm        <= p;
      stat_valid <= sv;
      pcm_valid  <= pv;
      @(posedge ref_clk);
      stat_valid <= 1'h0;
      pcm_valid  <= 1'h0;
      ctl_u.get_frame(f);
      chk(f, exp_frame(r, st_pend, st_exp, pc_pend, pc_exp));
      chk(codec_ready, r);
      // a frame sent while not ready leaves reports pending
      if (r)
      begin
         st_pend = 1'h0;
         pc_pend = 1'h0;
      end
   endtask

   initial
   begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end

   initial
   begin
      logic [31:0] rd;
      logic        er;
      acl_stat_t   s;
      acl_pcm_t    p;
      acl_regwr_t  hw [3];
      ref_clk = 1'h0;
      rstn = 1'h0;
      ce = 1'h1;
      {psel, penable, pwrite, paddr, pwdata, reg_wr_valid, reg_wr} = '0;
      {stat_valid, stat, pcm_valid, pcm} = '0;
      {st_pend, pc_pend, st_exp, pc_exp} = '0;
      n_errors = 0;
      tests_run = 0;
      void'($urandom(32'hC8E38B07));
      hw = '{'{7'h26, 16'hEFFF}, '{7'h24, 16'h1000}, '{7'h26, 16'h1000}};
      repeat (8) @(posedge ref_clk);
      rstn <= 1'h1;
      repeat (3) @(posedge ref_clk);
      apb(1'h0, REG_CTRL, 32'h0, rd, er);
      chk({er, rd}, {32'h0, CTRL_READY_EN_RST});
      apb(1'h1, 12'h010, 32'hFFFFFFFF, rd, er);
      chk(er, 1'h1);
      apb(1'h1, REG_CTRL, 32'hFFFFFFFE, rd, er);
      apb(1'h0, REG_CTRL, 32'h0, rd, er);
      chk({er, rd}, 33'h0);
      // random frames, first one before ready
      for (int k = 0; k < 6; k++)
      begin
         s = 23'($urandom);
         p = 36'({$urandom, $urandom});
         if (k == 1)
         begin
            s = '1;
            p = '1;
         end
         frame(k == 1 || (k > 1 && $urandom % 4 != 0), k < 2 || $urandom % 2, s,
               k < 2 || $urandom % 2, p);
      end
      // ready cleared, only the third write (26h with halt bit) halts the link
      apb(1'h1, REG_CTRL, 32'h0, rd, er);
      for (int j = 0; j < 3; j++)
      begin
         wr_reg(hw[j]);
         chk(link_halted, 1'(j == 2));
      end
      repeat (300) @(posedge ref_clk);
      chk({link_bit_clock, codec_to_ctrl_data, link_halted}, 3'h1);
      apb(1'h0, REG_STATUS, 32'h0, rd, er);
      chk(rd[ST_HALTED_BIT], 1'h1);
      ctl_u.wake();
      chk(link_halted, 1'h0);
      apb(1'h0, REG_CTRL, 32'h0, rd, er);
      chk(rd, 32'h0);
      apb(1'h0, REG_FRAMES, 32'h0, rd, er);
      chk(rd, 32'h6);
      apb(1'h0, REG_WAKES, 32'h0, rd, er);
      chk(rd, 32'h1);
      frame(1'h1, 1'h1, 23'h2A5A5A, 1'h1, 36'h987654321);
      // cold reset out of halt
      apb(1'h1, REG_CTRL, 32'h0, rd, er);
      wr_reg(hw[2]);
      rstn <= 1'h0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'h1;
      {st_pend, pc_pend} = 2'h0;
      repeat (3) @(posedge ref_clk);
      chk(link_halted, 1'h0);
      apb(1'h0, REG_CTRL, 32'h0, rd, er);
      chk(rd, 32'h1);
      apb(1'h0, REG_WAKES, 32'h0, rd, er);
      chk(rd, 32'h0);
      frame(1'h1, 1'h1, 23'h7F0001, 1'h0, 36'h0);
      stop_test();
   end
endmodule
